// ==== hdl/tp_host_ctrl.sv ====
`default_nettype none
`include "tp_host_defs.svh"
module tp_host_ctrl #(
   parameter int CW = 25
) (
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                io_cycle_request,
   input  wire logic                address_strobe,
   input  wire logic                command_select_bit,
   input  wire logic                readNotWrite,
   input  wire logic [7:0]          dataIn,
   output logic [7:0]               dataOut,
   output logic                     dataOutEn_n,
   input  wire logic                ext_timeout_pin_hi,
   input  wire logic                ext_timeout_pin_lo,
   input  wire logic                serialRxLine,
   input  wire tp_host_pkg::netevt_s netEvt,
   output tp_host_pkg::netcfg_s     netCfg,
   output logic                     reconfigStart,
   output logic                     lineIdle,
   output logic [CW-1:0]            respTimeoutCyc,
   output logic [CW-1:0]            idleTimeoutCyc,
   output logic                     irq_out
);
   // ==========================================================
   // state
   logic [7:0] mask_q;            // interrupt enable mask
   logic       receive_inhibited; // status bit 7
   logic       powerOn_q;         // status bit 4
   logic       topology_rebuild_flag;
   logic       tx_acked;
   logic       tx_available;
   logic       disTxPend_q;       // disable transmit waits for token
   logic       disRxPend_q;       // disable receive waits for token
   logic       strobe_q;          // delayed strobe for edge
   logic [CW-1:0] reconfCyc;      // reconfiguration limit
   logic       idleExp;           // idle watchdog fire
   logic       tokenExp;          // token watchdog fire
   logic       timeout_select_state_hi;
   logic       timeout_select_state_lo;
   logic [7:0] status;            // assembled status byte
   tp_host_pkg::hostop_e op;      // decoded operation
   logic       take;              // one cycle per host cycle
   logic       cmdWr;             // valid command write
   logic [2:0] opc;               // command opcode field
   logic       defined;           // command is a defined code
   // ==========================================================
   // timeout selection and watchdogs
   tp_timeout_sel #(.CW(CW)) u_sel (
      .tselHi    (ext_timeout_pin_hi),
      .tselLo    (ext_timeout_pin_lo),
      .respCyc   (respTimeoutCyc),
      .idleCyc   (idleTimeoutCyc),
      .reconfCyc (reconfCyc)
   );
   // line idle for 78.2 us; restarted by receive line activity
   tp_watchdog #(.CW(CW)) u_idle (
      .core_clk (core_clk),
      .rst      (rst),
      .restart  (!serialRxLine),
      .limit    (CW'(`NS2CYC(`LINE_IDLE_NS))),
      .expired  (idleExp)
   );
   // token watchdog
   tp_watchdog #(.CW(CW)) u_tok (
      .core_clk (core_clk),
      .rst      (rst),
      .restart  (netEvt.tokenSeen),
      .limit    (reconfCyc),
      .expired  (tokenExp)
   );
   assign reconfigStart = tokenExp;
   assign lineIdle      = idleExp;
   // ==========================================================
   // host cycle decode on strobe falling edge
   always_ff @(posedge core_clk) begin
      if (rst) begin
         strobe_q <= 1'b1;
      end else begin
         strobe_q <= address_strobe;
      end
   end
   assign take = strobe_q && !address_strobe && io_cycle_request;
   assign op   = tp_host_pkg::hostop_e'({command_select_bit, readNotWrite});
   assign opc  = dataIn[2:0];
   // defined codes only
   always_comb begin
      case (opc)
         `OP_DIS_TX, `OP_DIS_RX: defined = (dataIn[7:3] == 5'h00);
         `OP_EN_TX:              defined = (dataIn[7:5] == 3'h0);
         `OP_EN_RX:              defined = (dataIn[6:5] == 2'h0);
         `OP_CONFIG:             defined = (dataIn[7:4] == 4'h0);
         `OP_CLEAR:              defined = (dataIn[7:5] == 3'h0);
         default:                defined = 1'b0;
      endcase
   end
   assign cmdWr = take && op == tp_host_pkg::OP_CMD_WR && defined;
   // ==========================================================
   // status byte, pins read live
   assign timeout_select_state_hi = ext_timeout_pin_hi;
   assign timeout_select_state_lo = ext_timeout_pin_lo;
   always_comb begin
      status = 8'h00;
      status[`ST_RX_INHIBIT] = receive_inhibited;
      status[`ST_TSEL_HI]    = timeout_select_state_hi;
      status[`ST_TSEL_LO]    = timeout_select_state_lo;
      status[`ST_POWER_ON]   = powerOn_q;
      status[`ST_TEST]       = 1'b0;
      status[`ST_REBUILD]    = topology_rebuild_flag;
      status[`ST_TX_ACKED]   = tx_acked;
      status[`ST_TX_AVAIL]   = tx_available;
   end
   // read data registered, driven while strobe low
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dataOut     <= 8'h00;
         dataOutEn_n <= 1'b1;
      end else if (take && op == tp_host_pkg::OP_STAT_RD) begin
         dataOut     <= status;
         dataOutEn_n <= 1'b0;
      end else if (address_strobe) begin
         dataOutEn_n <= 1'b1;
      end
   end
   // ==========================================================
   // mask register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mask_q <= 8'h00;
      end else if (take && op == tp_host_pkg::OP_MASK_WR) begin
         mask_q <= dataIn;
      end
   end
   // ==========================================================
   // power-on flag: set by reset, cleared by command
   always_ff @(posedge core_clk) begin
      if (rst) begin
         powerOn_q <= 1'b1;
      end else if (cmdWr && opc == `OP_CLEAR && dataIn[3]) begin
         powerOn_q <= 1'b0;
      end
   end
   // rebuild flag: set wins over clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         topology_rebuild_flag <= 1'b0;
      end else if (idleExp) begin
         topology_rebuild_flag <= 1'b1;
      end else if (cmdWr && opc == `OP_CLEAR && dataIn[4]) begin
         topology_rebuild_flag <= 1'b0;
      end
   end
   // ==========================================================
   // transmit flags and pending work
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_available     <= 1'b1;
         tx_acked         <= 1'b0;
         netCfg.txPending <= 1'b0;
         netCfg.txPage    <= 2'h0;
         disTxPend_q      <= 1'b0;
      end else begin
         if (cmdWr && opc == `OP_EN_TX) begin
            tx_available     <= 1'b0;
            tx_acked         <= 1'b0;
            netCfg.txPending <= 1'b1;
            netCfg.txPage    <= dataIn[4:3];
            disTxPend_q      <= 1'b0; // a new enable overrides an older disable unless the token applies that disable in the same cycle
         end else if (cmdWr && opc == `OP_DIS_TX) begin
            disTxPend_q <= 1'b1;
         end
         if (netEvt.txAcked && !netEvt.txBcast) begin
            tx_acked <= 1'b1;
         end
         if (netEvt.txDone) begin
            tx_available     <= 1'b1;
            netCfg.txPending <= 1'b0;
         end
         if (netEvt.tokenSeen && disTxPend_q) begin
            disTxPend_q <= 1'b0;
            if (!netEvt.txDone) begin
               netCfg.txPending <= 1'b0;
               tx_available     <= 1'b1;
            end
         end
      end
   end
   // ==========================================================
   // receive flags and setup
   always_ff @(posedge core_clk) begin
      if (rst) begin
         receive_inhibited <= 1'b1;
         netCfg.rxEnabled  <= 1'b0;
         netCfg.rxPage     <= 2'h0;
         netCfg.rxBcast    <= 1'b0;
         disRxPend_q       <= 1'b0;
      end else begin
         if (cmdWr && opc == `OP_EN_RX) begin
            receive_inhibited <= 1'b0;
            netCfg.rxEnabled  <= 1'b1;
            netCfg.rxPage     <= dataIn[4:3];
            netCfg.rxBcast    <= dataIn[7];
            disRxPend_q       <= 1'b0; // a new enable overrides an older disable unless the token applies that disable in the same cycle
         end else if (cmdWr && opc == `OP_DIS_RX) begin
            disRxPend_q <= 1'b1;
         end
         if (netEvt.tokenSeen && disRxPend_q && !netEvt.rxStarted) begin
            disRxPend_q       <= 1'b0;
            receive_inhibited <= 1'b1;
            netCfg.rxEnabled  <= 1'b0;
         end
         if (netEvt.rxStored) begin
            receive_inhibited <= 1'b1;
            netCfg.rxEnabled  <= 1'b0;
            disRxPend_q       <= 1'b0;
         end
      end
   end
   // configuration
   always_ff @(posedge core_clk) begin
      if (rst) begin
         netCfg.longPkts <= 1'b0;
      end else if (cmdWr && opc == `OP_CONFIG) begin
         netCfg.longPkts <= dataIn[3];
      end
   end
   // ==========================================================
   // interrupt
   assign irq_out = powerOn_q
                  | (receive_inhibited & mask_q[`ST_RX_INHIBIT])
                  | (topology_rebuild_flag & mask_q[`ST_REBUILD])
                  | (tx_available & mask_q[`ST_TX_AVAIL]);
   // ==========================================================
   // checks
   // a status read taken on the strobe edge
   sequence stat_take_s;
      take && op == tp_host_pkg::OP_STAT_RD;
   endsequence
   // the status byte standing on the bus one edge later
   sequence stat_shown_s;
      !dataOutEn_n && dataOut == $past(status);
   endsequence
   chk_irq_power_on: assert property (@(posedge core_clk) disable iff (rst)
      powerOn_q |-> irq_out) else $error("power-on flag without irq");
   chk_irq_unmasked: assert property (@(posedge core_clk) disable iff (rst)
      (mask_q == 8'h00 && !powerOn_q) |-> !irq_out) else $error("irq with no cause");
   chk_irq_no_cause: assert property (@(posedge core_clk) disable iff (rst)
      !powerOn_q && !(receive_inhibited && mask_q[`ST_RX_INHIBIT])
      && !(topology_rebuild_flag && mask_q[`ST_REBUILD])
      && !(tx_available && mask_q[`ST_TX_AVAIL]) |-> !irq_out)
      else $error("irq from a bit that never interrupts");
   chk_status_read: assert property (@(posedge core_clk) disable iff (rst)
      stat_take_s |=> stat_shown_s) else $error("status byte not shown");
   chk_status_pins: assert property (@(posedge core_clk) disable iff (rst)
      stat_take_s |=> dataOut[6:5] == $past({ext_timeout_pin_hi, ext_timeout_pin_lo}))
      else $error("status pin bits wrong");
   chk_status_test: assert property (@(posedge core_clk) disable iff (rst)
      !dataOutEn_n |-> !dataOut[`ST_TEST]) else $error("test bit set");
   chk_entx_clears: assert property (@(posedge core_clk) disable iff (rst)
      cmdWr && opc == `OP_EN_TX && !netEvt.txDone && !netEvt.txAcked && !disTxPend_q
      |=> !tx_available && !tx_acked) else $error("enable transmit flags");
   chk_enrx_clears: assert property (@(posedge core_clk) disable iff (rst)
      cmdWr && opc == `OP_EN_RX && !netEvt.rxStored && !disRxPend_q
      |=> !receive_inhibited && netCfg.rxEnabled) else $error("enable receive flags");
   chk_token_disable: assert property (@(posedge core_clk) disable iff (rst)
      netEvt.tokenSeen && disTxPend_q |=> tx_available && !netCfg.txPending)
      else $error("disable transmit not applied");
   chk_rx_stored: assert property (@(posedge core_clk) disable iff (rst)
      netEvt.rxStored |=> receive_inhibited) else $error("stored packet not inhibited");
   chk_idle_rebuild: assert property (@(posedge core_clk) disable iff (rst)
      idleExp |=> topology_rebuild_flag) else $error("idle did not set rebuild");
   chk_clear_power: assert property (@(posedge core_clk) disable iff (rst)
      cmdWr && opc == `OP_CLEAR && dataIn[3] |=> !powerOn_q)
      else $error("power-on flag not cleared");
   chk_clear_rebuild: assert property (@(posedge core_clk) disable iff (rst)
      cmdWr && opc == `OP_CLEAR && dataIn[4] && !idleExp |=> !topology_rebuild_flag)
      else $error("rebuild flag not cleared");
   chk_bcast_noack: assert property (@(posedge core_clk) disable iff (rst)
      !tx_acked && netEvt.txBcast |=> !tx_acked)
      else $error("broadcast acked");
   chk_undef_ignored: assert property (@(posedge core_clk) disable iff (rst)
      take && op == tp_host_pkg::OP_CMD_WR && !defined && !idleExp |=>
      $stable(topology_rebuild_flag) && $stable(powerOn_q))
      else $error("undefined code acted");
endmodule
`default_nettype wire

// ==== hdl/tp_host_defs.svh ====
`ifndef TP_HOST_DEFS_SVH
`define TP_HOST_DEFS_SVH
// ==========================================================
// status and mask bit positions
`define ST_RX_INHIBIT     7
`define ST_TSEL_HI        6
`define ST_TSEL_LO        5
`define ST_POWER_ON       4
`define ST_TEST           3
`define ST_REBUILD        2
`define ST_TX_ACKED       1
`define ST_TX_AVAIL       0
// ==========================================================
// command opcodes in the low three bits
`define OP_DIS_TX         3'h1
`define OP_DIS_RX         3'h2
`define OP_EN_TX          3'h3
`define OP_EN_RX          3'h4
`define OP_CONFIG         3'h5
`define OP_CLEAR          3'h6
// ==========================================================
// timing figures in nanoseconds and milliseconds, and the clock period
`define CLK_PERIOD_NS     100
`define RESP_T11_NS       74700
`define RESP_T10_NS       283400
`define RESP_T01_NS       561800
`define RESP_T00_NS       1118600
`define IDLE_EXTRA_NS     3500
`define LINE_IDLE_NS      78200
`define RECONF_SHORT_MS   840
`define RECONF_LONG_MS    1680
// cycle counts: all times round down, nanosecond ones at least one cycle
`define NS2CYC(t)         (((t) / `CLK_PERIOD_NS) < 1 ? 1 : ((t) / `CLK_PERIOD_NS))
`define MS2CYC(t)         ((t) * 1000000 / `CLK_PERIOD_NS)
`endif

// ==== hdl/tp_host_pkg.sv ====
`default_nettype none
// ==========================================================
// shared types
package tp_host_pkg;
   // decoded host i/o operation
   typedef enum logic [1:0] {
      OP_MASK_WR,
      OP_STAT_RD,
      OP_CMD_WR,
      OP_RESERVED
   } hostop_e;
   // events reported by the network engine
   typedef struct packed {
      logic tokenSeen;   // token arrived at this node
      logic rxStarted;   // packet reception under way
      logic rxStored;    // packet written to enabled page
      logic txDone;      // transmit sequence finished
      logic txAcked;     // destination acknowledged
      logic txBcast;     // finished packet was broadcast
   } netevt_s;
   // settings handed to the network engine
   typedef struct packed {
      logic       txPending;
      logic [1:0] txPage;
      logic       rxEnabled;
      logic [1:0] rxPage;
      logic       rxBcast;
      logic       longPkts;
   } netcfg_s;
endpackage
`default_nettype wire

// ==== hdl/tp_timeout_sel.sv ====
`default_nettype none
`include "tp_host_defs.svh"
// ==========================================================
// timeout selection from the two static pins
module tp_timeout_sel #(
   parameter int CW = 25
) (
   input  wire logic          tselHi,
   input  wire logic          tselLo,
   output logic [CW-1:0]      respCyc,
   output logic [CW-1:0]      idleCyc,
   output logic [CW-1:0]      reconfCyc
);
   initial begin
      if (CW < 25) $error("counter width too small");
   end
   // response and reconfiguration per pin setting
   always_comb begin
      case ({tselHi, tselLo})
         2'b11: begin
            respCyc   = CW'(`NS2CYC(`RESP_T11_NS));
            reconfCyc = CW'(`MS2CYC(`RECONF_SHORT_MS));
         end
         2'b10: begin
            respCyc   = CW'(`NS2CYC(`RESP_T10_NS));
            reconfCyc = CW'(`MS2CYC(`RECONF_LONG_MS));
         end
         2'b01: begin
            respCyc   = CW'(`NS2CYC(`RESP_T01_NS));
            reconfCyc = CW'(`MS2CYC(`RECONF_LONG_MS));
         end
         default: begin
            respCyc   = CW'(`NS2CYC(`RESP_T00_NS));
            reconfCyc = CW'(`MS2CYC(`RECONF_LONG_MS));
         end
      endcase
      // idle is response plus fixed extra
      idleCyc = respCyc + CW'(`NS2CYC(`IDLE_EXTRA_NS));
   end
endmodule
`default_nettype wire

// ==== hdl/tp_watchdog.sv ====
`default_nettype none
// ==========================================================
// up counter that fires once when a limit is reached
module tp_watchdog #(
   parameter int CW = 25
) (
   input  wire logic          core_clk,
   input  wire logic          rst,
   input  wire logic          restart,
   input  wire logic [CW-1:0] limit,
   output logic              expired
);
   logic [CW-1:0] count_q; // cycles since restart
   initial begin
      if (CW < 2) $error("width too small");
   end
   // count, hold at limit
   always_ff @(posedge core_clk) begin
      if (rst || restart) begin
         count_q <= '0;
      end else if (count_q < limit) begin
         count_q <= count_q + CW'(1);
      end
   end
   // one pulse on reaching limit
   assign expired = !rst && !restart && (count_q == limit - CW'(1));
endmodule
`default_nettype wire

// ==== dv/tp_net_model.sv ====
`default_nettype none
// ==========================================================
// network engine stand-in: answers tokens and packets
module tp_net_model (
   input  wire logic                 core_clk,
   input  wire tp_host_pkg::netcfg_s netCfg,
   input  wire logic                 tokenGo,
   input  wire logic                 ackGo,
   input  wire logic                 bcastGo,
   input  wire logic                 rxBusy,
   input  wire logic                 rxEnd,
   input  wire logic                 halt_request_n,
   input  wire logic                 rxLine,
   output var logic                  gated_bit_clock,
   output var tp_host_pkg::netevt_s  netEvt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic txNow;   // transmit runs in the cycle after the token
   logic rxOk;    // receiver was enabled when the packet began
   initial netEvt = '0;
   initial txNow = 1'b0;
   initial rxOk = 1'b0;
   // ==========================================================
   // one-cycle event pulses, except rxStarted, which follows rxBusy
   always @(posedge core_clk) begin
      netEvt <= '0;
      netEvt.rxStarted <= rxBusy;
      netEvt.tokenSeen <= tokenGo;
      txNow <= tokenGo & netCfg.txPending;
      // acceptance decided when the packet starts
      if (rxBusy && !netEvt.rxStarted) begin
         rxOk <= netCfg.rxEnabled;
      end
      // finished transmit; an ack on a broadcast only when commanded
      if (txNow) begin
         netEvt.txDone  <= 1'b1;
         netEvt.txAcked <= ackGo;
         netEvt.txBcast <= bcastGo;
      end
      netEvt.rxStored <= rxEnd & rxOk;
   end
   // ==========================================================
   // external bit clock gate
   logic freeClk = 1'b0;  // free-running bit clock, half the core rate
   logic haltPrev = 1'b1; // halt request one edge ago
   logic armed = 1'b0;    // halt asked, waiting for a rising bit clock
   logic held = 1'b0;     // bit clock parked high
   // park on the rising edge after halt, run again once the line falls
   always @(posedge core_clk) begin
      freeClk <= !freeClk;
      haltPrev <= halt_request_n;
      if (haltPrev && !halt_request_n) begin
         armed <= 1'b1;
      end
      if (armed && !freeClk) begin
         held <= 1'b1;
         armed <= 1'b0;
      end else if (held && !rxLine) begin
         held <= 1'b0;
      end
   end
   assign gated_bit_clock = held | freeClk;
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`default_nettype none
`include "tp_host_defs.svh"
// ==========================================================
// self-checking bench for the host command block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk, rst, io_cycle_request, address_strobe, command_select_bit;
   logic        readNotWrite, dataOutEn_n, ext_timeout_pin_hi, ext_timeout_pin_lo;
   logic        serialRxLine, reconfigStart, lineIdle, irq_out;
   logic        halt_request_n, gated_bit_clock, g;
   logic        tokenGo, ackGo, bcastGo, rxBusy, rxEnd;
   logic [7:0]  dataIn, dataOut, rd, d;
   logic [1:0]  nn;
   logic [24:0] respTimeoutCyc, idleTimeoutCyc;
   tp_host_pkg::netevt_s netEvt;
   tp_host_pkg::netcfg_s netCfg;
   int          err_count = 0;
   int          n_checks = 0;
   int          idleCnt = 0;
   int          reconfCnt = 0;
   int          resp [4] = '{11186, 5618, 2834, 747};
   // reference model state
   int          ri, por, reb, ack, av, msk, txp, disTx, disRx, rxEn;
   tp_host_ctrl #(.CW(25)) tp_host_ctrl_inst (.core_clk(core_clk), .rst(rst),
      .io_cycle_request(io_cycle_request), .address_strobe(address_strobe),
      .command_select_bit(command_select_bit), .readNotWrite(readNotWrite),
      .dataIn(dataIn), .dataOut(dataOut), .dataOutEn_n(dataOutEn_n),
      .ext_timeout_pin_hi(ext_timeout_pin_hi), .ext_timeout_pin_lo(ext_timeout_pin_lo),
      .serialRxLine(serialRxLine), .netEvt(netEvt), .netCfg(netCfg),
      .reconfigStart(reconfigStart), .lineIdle(lineIdle), .respTimeoutCyc(respTimeoutCyc),
      .idleTimeoutCyc(idleTimeoutCyc), .irq_out(irq_out));
   tp_net_model tp_net_model_inst (.core_clk(core_clk), .netCfg(netCfg), .tokenGo(tokenGo),
      .ackGo(ackGo), .bcastGo(bcastGo), .rxBusy(rxBusy), .rxEnd(rxEnd),
      .halt_request_n(halt_request_n), .rxLine(serialRxLine),
      .gated_bit_clock(gated_bit_clock), .netEvt(netEvt));
   // ==========================================================
   // clock, idle-pulse counter and watchdog
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (lineIdle === 1'b1) idleCnt++;
      if (reconfigStart === 1'b1) reconfCnt++;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      close_out();
   end
   // ==========================================================
   // helpers
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // state after power-on reset
   task automatic preset();
      ri = 1;
      por = 1;
      av = 1;
      ack = 0;
      reb = 0;
      msk = 0;
      txp = 0;
      disTx = 0;
      disRx = 0;
      rxEnd = 0;
      rxEn = 0;
   endtask
   function automatic int expSt();
      return ri << 7 | ext_timeout_pin_hi << 6 | ext_timeout_pin_lo << 5 | por << 4
         | reb << 2 | ack << 1 | av;
   endfunction
   function automatic bit isDef(input logic [7:0] c);
      return c == 8'h01 || c == 8'h02 || (c[2:0] == 3'h3 && c[7:5] == 3'h0)
         || (c[2:0] == 3'h4 && c[6:5] == 2'h0) || (c[2:0] == 3'h5 && c[7:4] == 4'h0)
         || (c[2:0] == 3'h6 && c[7:5] == 3'h0);
   endfunction
   // one host i/o cycle: strobe falls, held one edge, then released
   task automatic io(input logic sel, input logic dir, input logic [7:0] v);
      @(posedge core_clk);
      #1;
      address_strobe = 1'b0;
      io_cycle_request = 1'b1;
      command_select_bit = sel;
      readNotWrite = dir;
      dataIn = v;
      @(posedge core_clk);
      #1;
      rd = dataOut;
      check(dataOutEn_n, !(~sel & dir));
      address_strobe = 1'b1;
      io_cycle_request = 1'b0;
      @(posedge core_clk);
      #1;
      check(dataOutEn_n, 1'b1);
   endtask
   task automatic status();
      io(1'b0, 1'b1, 8'h00);
      check(rd, expSt());
      check(irq_out, por | (ri & msk[7]) | (reb & msk[2]) | (av & msk[0]));
   endtask
   task automatic mask(input logic [7:0] m);
      io(1'b0, 1'b0, m);
      msk = m;
   endtask
   task automatic cmd(input logic [7:0] c);
      io(1'b1, 1'b0, c);
      // host sends only defined codes except in the refusal test
      if (isDef(c)) begin
         case (c[2:0])
            `OP_DIS_TX: disTx = 1;
            `OP_DIS_RX: disRx = 1;
            `OP_EN_TX: begin
               av = 0;
               ack = 0;
               txp = 1;
               disTx = 0;
            end
            `OP_EN_RX: begin
               ri = 0;
               rxEn = 1;
               disRx = 0;
            end
            `OP_CLEAR: begin
               if (c[3]) por = 0;
               if (c[4]) reb = 0;
            end
            default: ;
         endcase
      end
   endtask
   // token arrival, with the answer the destination gives
   task automatic tok(input logic a, input logic b);
      @(posedge core_clk);
      #1;
      tokenGo = 1'b1;
      ackGo = a;
      bcastGo = b;
      @(posedge core_clk);
      #1;
      tokenGo = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      if (txp && !disTx) ack = a && !b;
      if (txp || disTx) av = 1;
      if (disRx && !rxBusy) begin
         ri = 1;
         rxEn = 0;
         disRx = 0;
      end
      txp = 0;
      disTx = 0;
   endtask
   // one packet; mid issues a disable and a token during reception
   task automatic rxPkt(input bit mid);
      int ok;
      ok = rxEn;
      @(posedge core_clk);
      #1;
      rxBusy = 1'b1;
      if (mid) begin
         cmd(8'h02);
         tok(1'b0, 1'b0);
         status();
      end
      @(posedge core_clk);
      #1;
      rxBusy = 1'b0;
      rxEnd = 1'b1;
      @(posedge core_clk);
      #1;
      rxEnd = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      if (ok) begin
         ri = 1;
         rxEn = 0;
         disRx = 0;
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {io_cycle_request, command_select_bit, readNotWrite, dataIn} = '0;
      {tokenGo, ackGo, bcastGo, rxBusy, serialRxLine} = '0;
      {ext_timeout_pin_hi, ext_timeout_pin_lo} = 2'h0;
      address_strobe = 1'b1;
      halt_request_n = 1'b1;
      rst = 1'b1;
      preset();
      void'($urandom(78));
      repeat (4) @(posedge core_clk);
      #1;
      rst = 1'b0;
      // timeout pins: every setting, reset state on the first pass
      for (int i = 0; i < 4; i++) begin
         {ext_timeout_pin_hi, ext_timeout_pin_lo} = i[1:0];
         status();
         check(respTimeoutCyc, resp[i]);
         check(idleTimeoutCyc, resp[i] + 35);
      end
      mask(8'hFF);
      cmd(8'h0E);
      status();
      mask(8'h7A);
      status();
      // undefined codes and the reserved operation change nothing
      cmd(8'h00);
      repeat (6) begin
         d = 8'($urandom);
         while (isDef(d)) d = 8'($urandom);
         cmd(d);
      end
      status();
      io(1'b1, 1'b1, 8'hA5);
      status();
      // transmit: acknowledged, broadcast, cancelled, idle disable
      mask(8'h01);
      nn = 2'($urandom);
      cmd({3'h0, nn, 3'h3});
      status();
      check(netCfg.txPending, 1'b1);
      check(netCfg.txPage, nn);
      tok(1'b1, 1'b0);
      status();
      cmd(8'h1B);
      tok(1'b1, 1'b1);
      status();
      cmd(8'h0B);
      cmd(8'h01);
      tok(1'b0, 1'b0);
      status();
      cmd(8'h01);
      tok(1'b0, 1'b0);
      status();
      cmd(8'h01);
      cmd(8'h0B);
      tok(1'b1, 1'b0);
      status();
      // receive into random pages, with and without broadcasts
      mask(8'h80);
      repeat (4) begin
         d = {1'($urandom), 2'h0, 2'($urandom), 3'h4};
         cmd(d);
         status();
         check(netCfg.rxPage, d[4:3]);
         check(netCfg.rxBcast, d[7]);
         rxPkt(1'b0);
         status();
      end
      rxPkt(1'b0);
      status();
      cmd(8'h04);
      cmd(8'h02);
      tok(1'b0, 1'b0);
      status();
      cmd(8'h0C);
      rxPkt(1'b1);
      status();
      for (int c = 0; c < 2; c++) begin
         cmd({4'h0, c[0], 3'h5});
         check(netCfg.longPkts, c[0]);
      end
      // idle line raises the rebuild flag; only its clear bit drops it
      mask(8'h04);
      serialRxLine = 1'b1;
      halt_request_n = 1'b0;
      repeat (790) @(posedge core_clk);
      #1;
      check(gated_bit_clock, 1'b1);
      serialRxLine = 1'b0;
      check(idleCnt, 1);
      @(posedge core_clk);
      #1;
      g = gated_bit_clock;
      @(posedge core_clk);
      #1;
      check(gated_bit_clock, !g);
      halt_request_n = 1'b1;
      reb = 1;
      status();
      cmd(8'h0E);
      status();
      cmd(8'h16);
      status();
      // second reset in mid-run
      @(posedge core_clk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      rst = 1'b0;
      preset();
      status();
      check(netCfg, 8'h00);
      check(reconfCnt, 0);
      close_out();
   end
endmodule
`default_nettype wire
